// *** sidf_top.sv ***
// Self-ID status register, upper iso listen filter and APB slave.
//
// Functional notes
// - Reception error sets the identify phase fault.
// - Clean later reception clears the fault.
// - Hardware and host-write faults both set it.
// - Bus reset increments the 8-bit epoch.
// - Epoch wraps from 255 to zero.
// - Tally counts quadlets written, header included.
// - Tally clears when self-ID reception starts.
// - Reserved status bits read as zero.
// - Status at 68h, hardware updated, read only.
// - Filter set at 70h, clear at 74h.
// - Both filter addresses read the same value.
// - Filter bit n enables channel 32 plus n.
// - Self-ID buffer base is 2-Kbyte aligned.
`timescale 1ns/10ps
`include "sidf_consts.svh"
module sidf_top
   import sidf_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic BUS_RESET_PIN,
   input wire logic IDENT_START,
   input wire logic IDENT_DONE,
   input wire logic IDENT_RX_ERR,
   input wire logic QUAD_WRITTEN,
   input wire logic HOST_WR_ERR,
   input wire logic [5:0] ISO_CHAN,
   output logic [31:0] LISTEN_UPPER,
   output logic ISO_CHAN_HIT,
   output logic [20:0] BUF_BASE,
   output logic IRQ
);
   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   sidf_phase_type phase;
   sidf_phase_type next_phase;
   logic identify_phase_fault;
   logic [7:0] bus_reset_epoch;
   logic [8:0] identify_quadlet_tally;
   logic [31:0] iso_listen_filter_upper;
   logic [`SIDF_IRQ_W-1:0] irq_en;
   logic [`SIDF_IRQ_W-1:0] irq_stat;
   logic bus_reset_lvl;
   logic bus_reset_q;
   logic bus_reset_evt;
   logic fault_evt;
   logic done_evt;
   logic access;
   logic wr_acc;
   logic hit_tally;
   logic hit_fset;
   logic hit_fclr;
   logic hit_stat;
   logic hit_iclr;
   logic hit_ien;
   logic hit_base;
   logic mapped;
   logic [31:0] tally_word;
   logic [31:0] rd_mux;
   logic [31:0] next_filter;
   logic [`SIDF_IRQ_W-1:0] clr_mask;
   logic [20:0] buf_base;

   // Address match; one function serves every register decode.
   function automatic logic addr_is(input logic [11:0] a, input logic [11:0] ref_a);
      addr_is = (a == ref_a);
   endfunction

   // ----------------------------------------------------------------------
   // Bus reset pin crossing and edge detect
   // ----------------------------------------------------------------------
   sidf_sync u_rst_sync (
      .clk(REF_CLK),
      .rst_n(RST_N),
      .din(BUS_RESET_PIN),
      .dout(bus_reset_lvl)
   );

   // Rising edge of the filtered level marks one bus reset.
   assign bus_reset_evt = bus_reset_lvl & ~bus_reset_q;

   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         bus_reset_q <= 1'b0;
      end else begin
         bus_reset_q <= bus_reset_lvl;
      end
   end

   // ----------------------------------------------------------------------
   // Self-ID reception phase tracking
   // ----------------------------------------------------------------------
   // Any fault during reception, from the wire or from the host write path.
   assign fault_evt = (phase == SIDF_RECV || phase == SIDF_FAIL) &&
                      (IDENT_RX_ERR || HOST_WR_ERR);
   assign done_evt = IDENT_DONE && (phase != SIDF_IDLE);

   always_comb begin
      next_phase = phase;
      case (phase)
         SIDF_IDLE: begin
            if (IDENT_START) begin
               next_phase = SIDF_RECV;
            end
         end
         SIDF_RECV: begin
            if (IDENT_START) begin
               next_phase = SIDF_RECV;
            end else if (IDENT_DONE) begin
               next_phase = SIDF_IDLE;
            end else if (fault_evt) begin
               next_phase = SIDF_FAIL;
            end
         end
         SIDF_FAIL: begin
            if (IDENT_START) begin
               next_phase = SIDF_RECV;
            end else if (IDENT_DONE) begin
               next_phase = SIDF_IDLE;
            end
         end
         default: begin
            next_phase = SIDF_IDLE;
         end
      endcase
   end

   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         phase <= SIDF_IDLE;
      end else begin
         phase <= next_phase;
      end
   end

   // ----------------------------------------------------------------------
   // Fault flag
   // ----------------------------------------------------------------------
   // The flag shows the outcome of the latest reception: a fault sets it at once,
   // and only a clean completion clears it; a fault in the finishing cycle still counts.
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         identify_phase_fault <= 1'b0;
      end else if (fault_evt) begin
         identify_phase_fault <= 1'b1;
      end else if (done_evt && phase == SIDF_RECV) begin
         identify_phase_fault <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Generation epoch and quadlet tally
   // ----------------------------------------------------------------------
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         bus_reset_epoch <= `SIDF_EPOCH_RST;
      end else if (bus_reset_evt) begin
         // 8-bit add rolls 255 over to 0 by itself.
         bus_reset_epoch <= bus_reset_epoch + `SIDF_EPOCH_ONE;
      end
   end

   // The tally saturates rather than wrap; a wrapped count would lie about
   // how much of the buffer holds data.
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         identify_quadlet_tally <= `SIDF_TALLY_RST;
      end else if (IDENT_START) begin
         identify_quadlet_tally <= `SIDF_TALLY_RST;
      end else if (QUAD_WRITTEN && phase != SIDF_IDLE &&
                   identify_quadlet_tally != `SIDF_TALLY_MAX) begin
         identify_quadlet_tally <= identify_quadlet_tally + `SIDF_TALLY_ONE;
      end
   end

   // Reserved positions stay zero by construction.
   always_comb begin
      tally_word = `SIDF_ZERO32;
      tally_word[`SIDF_FAULT_BIT] = identify_phase_fault;
      tally_word[`SIDF_EPOCH_MSB:`SIDF_EPOCH_LSB] = bus_reset_epoch;
      tally_word[`SIDF_TALLY_MSB:`SIDF_TALLY_LSB] = identify_quadlet_tally;
   end

   // ----------------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------------
   assign access = PSEL && PENABLE && !PREADY;
   assign wr_acc = access && PWRITE;
   assign hit_tally = addr_is(PADDR, `SIDF_ADDR_TALLY);
   assign hit_fset = addr_is(PADDR, `SIDF_ADDR_FSET);
   assign hit_fclr = addr_is(PADDR, `SIDF_ADDR_FCLR);
   assign hit_stat = addr_is(PADDR, `SIDF_ADDR_IRQ_STAT);
   assign hit_iclr = addr_is(PADDR, `SIDF_ADDR_IRQ_CLR);
   assign hit_ien = addr_is(PADDR, `SIDF_ADDR_IRQ_EN);
   assign hit_base = addr_is(PADDR, `SIDF_ADDR_BUF_BASE);
   assign mapped = hit_tally | hit_fset | hit_fclr | hit_stat | hit_iclr |
                   hit_ien | hit_base;

   // Set and clear addresses both read the live filter.
   assign rd_mux = hit_tally ? tally_word :
                   (hit_fset | hit_fclr) ? iso_listen_filter_upper :
                   hit_stat ? {29'h000_0000, irq_stat} :
                   hit_ien ? {29'h000_0000, irq_en} :
                   hit_base ? {buf_base, 11'h000} : `SIDF_ZERO32;

   // Ones set or clear, zeros keep; the status word ignores writes.
   assign next_filter = (wr_acc && hit_fset) ? (iso_listen_filter_upper | PWDATA) :
                        (wr_acc && hit_fclr) ? (iso_listen_filter_upper & ~PWDATA) :
                        iso_listen_filter_upper;
   assign clr_mask = (wr_acc && hit_iclr) ? PWDATA[`SIDF_IRQ_W-1:0] : `SIDF_IRQ_RST;

   // ----------------------------------------------------------------------
   // APB answer: one wait state, then PREADY for one cycle
   // ----------------------------------------------------------------------
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA <= `SIDF_ZERO32;
      end else begin
         PREADY <= access;
         // Unmapped addresses and writes to the read-only status error out.
         PSLVERR <= access && (!mapped || (PWRITE && (hit_tally || hit_stat)));
         PRDATA <= (access && !PWRITE) ? rd_mux : `SIDF_ZERO32;
      end
   end

   // ----------------------------------------------------------------------
   // Software registers
   // ----------------------------------------------------------------------
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         iso_listen_filter_upper <= `SIDF_ZERO32;
         irq_en <= `SIDF_IRQ_RST;
         buf_base <= `SIDF_BASE_RST;
      end else begin
         iso_listen_filter_upper <= next_filter;
         if (wr_acc && hit_ien) begin
            irq_en <= PWDATA[`SIDF_IRQ_W-1:0];
         end
         if (wr_acc && hit_base) begin
            // Low 11 bits are not stored, forcing 2-Kbyte alignment.
            buf_base <= PWDATA[31:`SIDF_BASE_LSB];
         end
      end
   end

   // ----------------------------------------------------------------------
   // Outputs toward the receive path
   // ----------------------------------------------------------------------
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         LISTEN_UPPER <= `SIDF_ZERO32;
         ISO_CHAN_HIT <= 1'b0;
         BUF_BASE <= `SIDF_BASE_RST;
      end else begin
         LISTEN_UPPER <= next_filter;
         // Upper half only: channel 32 plus n selects bit n.
         ISO_CHAN_HIT <= ISO_CHAN[5] && next_filter[ISO_CHAN[4:0]];
         BUF_BASE <= buf_base;
      end
   end

   // ----------------------------------------------------------------------
   // Interrupts
   // ----------------------------------------------------------------------
   sidf_irq u_irq (
      .clk(REF_CLK),
      .rst_n(RST_N),
      .event_pulse({done_evt, fault_evt, bus_reset_evt}),
      .clr_mask(clr_mask),
      .enable(irq_en),
      .status(irq_stat),
      .irq(IRQ)
   );

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   a_fault_sets: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      fault_evt |=> identify_phase_fault)
      else $error("fault flag not set after error");
   a_fault_clears: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (done_evt && phase == SIDF_RECV && !fault_evt) |=> !identify_phase_fault)
      else $error("fault flag not cleared after clean reception");
   a_host_fault: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (phase == SIDF_RECV && HOST_WR_ERR) |=> identify_phase_fault)
      else $error("host write error ignored");
   a_epoch_step: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      bus_reset_evt |=> bus_reset_epoch == $past(bus_reset_epoch) + 8'h01)
      else $error("epoch did not step");
   a_epoch_wrap: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (bus_reset_evt && bus_reset_epoch == 8'hFF) |=> bus_reset_epoch == 8'h00)
      else $error("epoch did not wrap");
   a_tally_zero: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      IDENT_START |=> identify_quadlet_tally == 9'h000)
      else $error("tally not cleared at start");
   a_filter_rw: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (wr_acc && hit_fset) |=> (iso_listen_filter_upper & $past(PWDATA)) == $past(PWDATA))
      else $error("set write lost");
   a_read_same: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (access && !PWRITE && hit_fclr) |=> PRDATA == $past(iso_listen_filter_upper))
      else $error("clear address read mismatch");
   a_rsvd_zero: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (access && !PWRITE && hit_tally) |=> (PRDATA & 32'h7F00_F803) == 32'h0000_0000)
      else $error("reserved bits not zero");
   // Counting, refusal, filter and alignment checks; each looks one edge past its trigger.
   a_tally_count: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (QUAD_WRITTEN && phase != SIDF_IDLE && !IDENT_START &&
       identify_quadlet_tally != `SIDF_TALLY_MAX) |=>
      identify_quadlet_tally == $past(identify_quadlet_tally) + `SIDF_TALLY_ONE)
      else $error("tally did not count a quadlet");
   a_tally_sat: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (!IDENT_START && identify_quadlet_tally == `SIDF_TALLY_MAX) |=>
      identify_quadlet_tally == `SIDF_TALLY_MAX)
      else $error("tally left its ceiling");
   a_status_ro: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (wr_acc && hit_tally) |=> (PREADY && PSLVERR))
      else $error("status write not refused");
   a_clear_bits: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (wr_acc && hit_fclr) |=> (iso_listen_filter_upper & $past(PWDATA)) == `SIDF_ZERO32)
      else $error("clear write left bits set");
   a_low_miss: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      !ISO_CHAN[5] |=> !ISO_CHAN_HIT)
      else $error("lower channel reported a hit");
   a_base_align: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      (access && !PWRITE && hit_base) |=> PRDATA[`SIDF_BASE_LSB-1:0] == 11'h000)
      else $error("buffer base read not aligned");
   c_bus_reset: cover property (@(posedge REF_CLK) disable iff (!RST_N) bus_reset_evt);
   c_epoch_wrap: cover property (@(posedge REF_CLK) disable iff (!RST_N)
      bus_reset_evt && bus_reset_epoch == 8'hFF);
   c_clean_rx: cover property (@(posedge REF_CLK) disable iff (!RST_N)
      IDENT_START ##[1:50] (done_evt && !identify_phase_fault));
   c_fault_rx: cover property (@(posedge REF_CLK) disable iff (!RST_N) fault_evt ##1 IRQ);
endmodule

// *** sidf_consts.svh ***
// Offsets, field positions, reset values and counts for the self-ID status and filter block.
`ifndef SIDF_CONSTS_SVH
`define SIDF_CONSTS_SVH
// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define SIDF_ADDR_TALLY 12'h0068
`define SIDF_ADDR_FSET 12'h0070
`define SIDF_ADDR_FCLR 12'h0074
`define SIDF_ADDR_IRQ_STAT 12'h0090
`define SIDF_ADDR_IRQ_CLR 12'h0094
`define SIDF_ADDR_IRQ_EN 12'h0098
`define SIDF_ADDR_BUF_BASE 12'h009C
// ----------------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------------
`define SIDF_FAULT_BIT 31
`define SIDF_EPOCH_LSB 16
`define SIDF_EPOCH_MSB 23
`define SIDF_TALLY_LSB 2
`define SIDF_TALLY_MSB 10
`define SIDF_BASE_LSB 11
`define SIDF_IRQ_W 3
`define SIDF_IRQ_RESET 0
`define SIDF_IRQ_FAULT 1
`define SIDF_IRQ_DONE 2
// ----------------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------------
`define SIDF_ZERO32 32'h0000_0000
`define SIDF_EPOCH_RST 8'h00
`define SIDF_EPOCH_ONE 8'h01
`define SIDF_TALLY_RST 9'h000
`define SIDF_TALLY_ONE 9'h001
`define SIDF_TALLY_MAX 9'h1FF
`define SIDF_IRQ_RST 3'h0
`define SIDF_BASE_RST 21'h00_0000
`endif

// *** sidf_pkg.sv ***
// Types shared by the self-ID status and filter block.
package sidf_pkg;
   typedef enum logic [2:0] {
      SIDF_IDLE = 3'b001,
      SIDF_RECV = 3'b010,
      SIDF_FAIL = 3'b100
   } sidf_phase_type;
endpackage

// *** sidf_sync.sv ***
// Three-stage synchroniser with agreement filter for one pin input.
`timescale 1ns/10ps
module sidf_sync (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic din,
   output logic dout
);
   logic s1;
   logic s2;
   logic s3;
   // ----------------------------------------------------------------------
   // Shift chain; s1 feeds only s2 to keep metastability contained.
   // ----------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
         dout <= 1'b0;
      end else begin
         s1 <= din;
         s2 <= s1;
         s3 <= s2;
         // A change counts once the second and third stages agree.
         if (s2 == s3) begin
            dout <= s3;
         end
      end
   end
endmodule

// *** sidf_irq.sv ***
// Sticky interrupt status, write-one clear and enable for the block's events.
`timescale 1ns/10ps
`include "sidf_consts.svh"
module sidf_irq (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [`SIDF_IRQ_W-1:0] event_pulse,
   input wire logic [`SIDF_IRQ_W-1:0] clr_mask,
   input wire logic [`SIDF_IRQ_W-1:0] enable,
   output logic [`SIDF_IRQ_W-1:0] status,
   output logic irq
);
   logic [`SIDF_IRQ_W-1:0] next_status;
   // Set wins over clear so no event is lost in the clearing cycle.
   assign next_status = (status & ~clr_mask) | event_pulse;
   // ----------------------------------------------------------------------
   // Status and level output, both registered.
   // ----------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         status <= `SIDF_IRQ_RST;
         irq <= 1'b0;
      end else begin
         status <= next_status;
         irq <= |(next_status & enable);
      end
   end
endmodule

// *** sidf_phy_model.sv ***
// Far-side model: bus reset pin, self-ID reception events and iso channel probe.
`timescale 1ns/10ps
module sidf_phy_model (
   input wire logic clk,
   output logic bus_reset,
   output logic id_start,
   output logic id_done,
   output logic id_rx_err,
   output logic quad_wr,
   output logic host_err,
   output logic [5:0] chan,
   input wire logic chan_hit
);
   // Idle levels from time zero, so the block never sees an unknown event.
   initial begin
      bus_reset = 1'b0;
      id_start = 1'b0;
      id_done = 1'b0;
      id_rx_err = 1'b0;
      quad_wr = 1'b0;
      host_err = 1'b0;
      chan = 6'h00;
   end

   // The pin is held well past the three-stage filter so a short glitch is never the test.
   task automatic pulse_reset();
      @(posedge clk);
      bus_reset <= 1'b1;
      repeat (6) @(posedge clk);
      bus_reset <= 1'b0;
      repeat (6) @(posedge clk);
   endtask

   // One reception: start, a burst of quadlet writes, optional faults, then done.
   task automatic self_id(input int quads, input logic rx_bad, input logic host_bad);
      @(posedge clk);
      id_start <= 1'b1;
      @(posedge clk);
      id_start <= 1'b0;
      if (quads > 0) begin
         quad_wr <= 1'b1;
         repeat (quads) @(posedge clk);
         quad_wr <= 1'b0;
      end
      id_rx_err <= rx_bad;
      host_err <= host_bad;
      @(posedge clk);
      id_rx_err <= 1'b0;
      host_err <= 1'b0;
      id_done <= 1'b1;
      @(posedge clk);
      id_done <= 1'b0;
      repeat (4) @(posedge clk);
   endtask

   // The hit flag is registered, so it is looked at two edges after the channel changes.
   task automatic probe(input logic [5:0] ch, output logic hit);
      @(posedge clk);
      chan <= ch;
      repeat (2) @(posedge clk);
      hit = chan_hit;
   endtask
endmodule

// *** selfid_status_iso_rx_filter_bench.sv ***
// Self-checking bench: APB register tests and far-side event sequences.
`timescale 1ns/10ps
`include "sidf_consts.svh"
module selfid_status_iso_rx_filter_bench;
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr, hit, irq, h, err;
   logic bres, ids, idd, irx, qw, hwe;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, listen, rd;
   logic [20:0] base;
   logic [5:0] ch;
   logic [5:0] chans [6] = '{6'h20, 6'h21, 6'h24, 6'h3F, 6'h01, 6'h30};
   logic hits [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
   int bad_count = 0;
   int comparisons = 0;

   sidf_top DUT (.REF_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .BUS_RESET_PIN(bres), .IDENT_START(ids), .IDENT_DONE(idd),
      .IDENT_RX_ERR(irx), .QUAD_WRITTEN(qw), .HOST_WR_ERR(hwe), .ISO_CHAN(ch),
      .LISTEN_UPPER(listen), .ISO_CHAN_HIT(hit), .BUF_BASE(base), .IRQ(irq));
   sidf_phy_model phy (.clk(clk), .bus_reset(bres), .id_start(ids), .id_done(idd),
      .id_rx_err(irx), .quad_wr(qw), .host_err(hwe), .chan(ch), .chan_hit(hit));

   // ----------------------------------------------------------------------
   // Clock and shared tasks
   // ----------------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // The request is held until pready is sampled high; the wait is bounded, not assumed.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 40);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 40) check("apb ready", 32'h0000_0000, 32'h0000_0001);
   endtask

   task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp,
                        input logic xerr);
      apb(1'b0, a, 32'h0000_0000);
      check(what, rd, exp);
      check("read error flag", {31'h0000_0000, err}, {31'h0000_0000, xerr});
   endtask

   task automatic wrchk(input logic [11:0] a, input logic [31:0] d, input logic xerr);
      apb(1'b1, a, d);
      check("write error flag", {31'h0000_0000, err}, {31'h0000_0000, xerr});
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // A hang anywhere ends the run through the same closing task.
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      $display("[FAIL] watchdog expected finish seen timeout");
      tally_and_finish();
   end

   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      rdchk("status reset", `SIDF_ADDR_TALLY, 32'h0000_0000, 1'b0);
      wrchk(`SIDF_ADDR_TALLY, 32'hFFFF_FFFF, 1'b1);
      rdchk("status kept", `SIDF_ADDR_TALLY, 32'h0000_0000, 1'b0);
      wrchk(`SIDF_ADDR_FSET, 32'hA5A5_0F0F, 1'b0);
      wrchk(`SIDF_ADDR_FSET, 32'h0000_0000, 1'b0);
      rdchk("filter set", `SIDF_ADDR_FSET, 32'hA5A5_0F0F, 1'b0);
      wrchk(`SIDF_ADDR_FCLR, 32'h0000_0F01, 1'b0);
      rdchk("filter clear", `SIDF_ADDR_FCLR, 32'hA5A5_000E, 1'b0);
      rdchk("filter via set", `SIDF_ADDR_FSET, 32'hA5A5_000E, 1'b0);
      check("filter copy", listen, 32'hA5A5_000E);
      // Channels below 32 must miss even where the matching low bit is set.
      foreach (chans[i]) begin
         phy.probe(chans[i], h);
         check("channel hit", {31'h0000_0000, h}, {31'h0000_0000, hits[i]});
      end
      phy.pulse_reset();
      rdchk("epoch one", `SIDF_ADDR_TALLY, 32'h0001_0000, 1'b0);
      repeat (254) phy.pulse_reset();
      rdchk("epoch top", `SIDF_ADDR_TALLY, 32'h00FF_0000, 1'b0);
      phy.pulse_reset();
      rdchk("epoch wrap", `SIDF_ADDR_TALLY, 32'h0000_0000, 1'b0);
      phy.self_id(5, 1'b0, 1'b0);
      rdchk("five quadlets", `SIDF_ADDR_TALLY, 32'h0000_0014, 1'b0);
      phy.self_id(0, 1'b0, 1'b0);
      rdchk("tally restart", `SIDF_ADDR_TALLY, 32'h0000_0000, 1'b0);
      phy.self_id(3, 1'b1, 1'b0);
      rdchk("receive fault", `SIDF_ADDR_TALLY, 32'h8000_000C, 1'b0);
      phy.self_id(2, 1'b0, 1'b0);
      rdchk("fault cleared", `SIDF_ADDR_TALLY, 32'h0000_0008, 1'b0);
      phy.self_id(1, 1'b0, 1'b1);
      rdchk("host fault", `SIDF_ADDR_TALLY, 32'h8000_0004, 1'b0);
      // One quadlet past the ceiling shows the tally saturating instead of wrapping.
      phy.self_id(512, 1'b0, 1'b0);
      rdchk("full tally", `SIDF_ADDR_TALLY, 32'h0000_07FC, 1'b0);
      // Interrupts: all three events seen so far, none enabled yet.
      rdchk("irq status", `SIDF_ADDR_IRQ_STAT, 32'h0000_0007, 1'b0);
      check("irq masked", {31'h0000_0000, irq}, 32'h0000_0000);
      wrchk(`SIDF_ADDR_IRQ_EN, 32'h0000_0002, 1'b0);
      rdchk("irq enable", `SIDF_ADDR_IRQ_EN, 32'h0000_0002, 1'b0);
      check("irq raised", {31'h0000_0000, irq}, 32'h0000_0001);
      wrchk(`SIDF_ADDR_IRQ_CLR, 32'h0000_0002, 1'b0);
      rdchk("irq one cleared", `SIDF_ADDR_IRQ_STAT, 32'h0000_0005, 1'b0);
      check("irq low", {31'h0000_0000, irq}, 32'h0000_0000);
      wrchk(`SIDF_ADDR_IRQ_CLR, 32'h0000_0007, 1'b0);
      rdchk("irq clear reads", `SIDF_ADDR_IRQ_CLR, 32'h0000_0000, 1'b0);
      wrchk(`SIDF_ADDR_IRQ_STAT, 32'h0000_0007, 1'b1);
      wrchk(`SIDF_ADDR_IRQ_EN, 32'h0000_0001, 1'b0);
      phy.pulse_reset();
      check("irq on reset", {31'h0000_0000, irq}, 32'h0000_0001);
      rdchk("unmapped read", 12'h0FC, 32'h0000_0000, 1'b1);
      wrchk(12'h0FC, 32'hFFFF_FFFF, 1'b1);
      wrchk(`SIDF_ADDR_BUF_BASE, 32'hFFFF_FFFF, 1'b0);
      rdchk("buffer base", `SIDF_ADDR_BUF_BASE, 32'hFFFF_F800, 1'b0);
      check("base port", {11'h000, base}, 32'h001F_FFFF);
      // A second reset mid-run must bring every register back to its idle value.
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rdchk("filter after reset", `SIDF_ADDR_FSET, 32'h0000_0000, 1'b0);
      rdchk("status after reset", `SIDF_ADDR_TALLY, 32'h0000_0000, 1'b0);
      check("base after reset", {11'h000, base}, 32'h0000_0000);
      check("listen after reset", listen, 32'h0000_0000);
      check("irq after reset", {31'h0000_0000, irq}, 32'h0000_0000);
      tally_and_finish();
   end
endmodule
